// file: src/clock_switch.sv
// Purpose: Dynamic clock switch with protected commands, availability counter and clock output.
// Assumes: Source oscillations arrive as one-cycle ticks synchronous to clk.
// Notes: The system clock gates change only on source edges so no runt pulse escapes.
`timescale 1ns/100ps

// Overview of operation
// [R1] Low-frequency crystal start-up and reset delays
// [R2] Timer may start low-frequency oscillator itself
// [R3] External clock start-up six cycles, reset delays
// [R4] External setting 00 adds 4 ms when pin fuse
// [R5] Timer may enable external clock input itself
// [R6] System clock drives output pin without crystal
// [R7] No clock on output pin during reset
// [R8] Output pin carries the divided system clock
// [R9] Source switching is glitch free
// [R10] Command register changes only after protected unlock
// [R11] Each written value launches at most one command
// [R12] Fuses copied into selection register at reset
// [R13] Commands take parameters from selection register
// [R14] Enable turns on selected source with start-up
// [R15] Enable starts availability count automatically
// [R16] Disable refused for the system clock source
// [R17] Each source latches its own enable
// [R18] Request counts source cycles to start-up limit
// [R19] Ready clears at count start, then holds
// [R20] Recover writes system source code into select
// [R21] Switch moves system clock to any source
// [R22] Software confirms new source before switching
// [R23] Unlock write precedes every command write
// [R24] Fixed command byte encodings
// [R25] Only one external source enabled at once
// [R26] Request uses code 03, unknown codes ignored
// [R27] Unlock expires after four cycles
module clock_switch #(
   parameter int DELAY_SHORT_CYC = clock_switch_pkg::RST_DELAY_SHORT_CYC,
   parameter int DELAY_PIN_CYC = clock_switch_pkg::RST_DELAY_PIN_CYC,
   parameter int DELAY_LONG_CYC = clock_switch_pkg::RST_DELAY_LONG_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire clock_switch_pkg::apb_req_t apbReq,
   output clock_switch_pkg::apb_rsp_t apbRsp,
   input wire clock_switch_pkg::fuse_t lowFuse,
   input wire logic [4:0] sourceTick,
   input wire logic divTick,
   input wire logic timerWantsLf,
   input wire logic timerWantsExt,
   output logic [4:0] oscEnable,
   output logic [4:0] sysGate,
   output logic clockOutPin,
   output logic clockOutOe,
   output logic wdAutoReload,
   output logic resetDone
);
   import clock_switch_pkg::*;

   // Maps a source code to {valid, index}.
   function automatic logic [3:0] codeToIdx(input logic [3:0] code);
      logic [3:0] result;
      result = 4'h0;
      if (code[3]) begin
         result = {1'b1, IDX_XTAL};
      end else begin
         case (code)
            CODE_EXT: result = {1'b1, IDX_EXT};
            CODE_RC: result = {1'b1, IDX_RC};
            CODE_WD: result = {1'b1, IDX_WD};
            CODE_LF: result = {1'b1, IDX_LF};
            default: result = 4'h0;
         endcase
      end
      return result;
   endfunction

   // Start-up count limit for a source code and start-up setting.
   function automatic logic [15:0] startLimit(input logic [3:0] code, input logic [1:0] sut);
      logic [15:0] limit;
      limit = LIM_FAST;
      if (code[3]) begin
         // Crystal: bit 0 of the code extends the start-up setting.
         case ({code[0], sut})
            3'h0, 3'h1: limit = LIM_258;
            3'h2, 3'h3, 3'h4: limit = LIM_1K;
            default: limit = LIM_16K;
         endcase
      end else if (sut == SUT_RESERVED) begin
         // Reserved setting takes the longest count to stay safe.
         limit = LIM_32K;
      end else if (code == CODE_LF) begin
         limit = (sut == 2'h2) ? LIM_32K : LIM_1K; // [R1]
      end else begin
         limit = LIM_FAST; // [R3]
      end
      return limit;
   endfunction

   sel_reg_t selReg; // Clock selection register.
   logic unlocked; // Change enable armed.
   logic [2:0] unlockAge; // Cycles since the unlock write.
   logic [4:0] srcEnable; // Software enables, one per source.
   logic [3:0] sysCode; // Code of the source driving the system clock.
   logic [2:0] sysIdx; // Index of that source.
   logic srcReady; // Availability ready flag.
   logic counting; // Availability count running.
   logic [2:0] countIdx; // Source being counted.
   logic [15:0] countLimit; // Latched count limit.
   logic [15:0] countValue; // Source cycles counted so far.
   switch_state_t swState; // Switch sequencer state.
   logic [2:0] swIdx; // Target source of a switch.
   logic [3:0] swCode; // Target code of a switch.
   reset_state_t rsState; // Reset delay sequencer state.
   logic [22:0] rsCount; // Reset delay counter.

   // Bus decode: a transfer completes when the registered ready is seen.
   wire apbDone = apbReq.psel & apbReq.penable & apbRsp.pready;
   wire apbWr = apbDone & apbReq.pwrite;
   wire selWrite = apbWr & (apbReq.paddr == ADDR_SELECT);
   wire cmdWrite = apbWr & (apbReq.paddr == ADDR_COMMAND);
   wire [7:0] cmdByte = apbReq.pwdata[7:0];
   wire unlockHit = cmdWrite & (cmdByte == CMD_UNLOCK); // [R23]
   wire execCmd = cmdWrite & unlocked & ~unlockHit; // [R10]
   wire mapped = (apbReq.paddr == ADDR_SELECT) | (apbReq.paddr == ADDR_COMMAND) | (apbReq.paddr == ADDR_STATUS);

   // Parameters of every command come from the selection register.
   wire [3:0] selDecode = codeToIdx(selReg.sourceSelectField); // [R13]
   wire selValid = selDecode[3];
   wire [2:0] selIdx = selDecode[2:0];
   wire swIdle = (swState == SW_IDLE);
   // Another external source already drives the system clock.
   wire extConflict = (selIdx >= IDX_EXT) & (sysIdx >= IDX_EXT) & (sysIdx != selIdx); // [R25]

   // Exclusive decode: each byte selects one operation or none.
   wire doEnable = execCmd & (cmdByte == CMD_ENABLE) & selValid & ~extConflict; // [R11] [R14]
   wire doDisable = execCmd & (cmdByte == CMD_DISABLE) & selValid & (selIdx != sysIdx) & swIdle; // [R16]
   wire doRequest = execCmd & (cmdByte == CMD_REQUEST) & selValid; // [R26]
   wire doSwitch = execCmd & (cmdByte == CMD_SWITCH) & selValid & srcEnable[selIdx] & swIdle; // [R21]
   wire doRecover = execCmd & (cmdByte == CMD_RECOVER); // [R20]
   wire doWdAuto = execCmd & (cmdByte == CMD_WD_AUTO);
   wire countStart = doEnable | doRequest; // [R15] [R18]

   // Next enables: an external enable drops the other externals.
   wire [4:0] enableSet = doEnable ? 5'(5'h01 << selIdx) : 5'h00;
   wire [4:0] enableKeep = (doEnable & (selIdx >= IDX_EXT)) ? ~EXT_MASK : 5'h1F; // [R25]
   wire [4:0] enableDrop = doDisable ? 5'(5'h01 << selIdx) : 5'h00;
   wire [4:0] next_srcEnable = ((srcEnable & enableKeep) | enableSet) & ~enableDrop; // [R17]

   // The timer may bring up a shared source when no other external runs.
   wire lfTimer = timerWantsLf & ~srcEnable[IDX_XTAL] & ~srcEnable[IDX_EXT]; // [R2]
   wire extTimer = timerWantsExt & ~srcEnable[IDX_XTAL] & ~srcEnable[IDX_LF] & ~lfTimer; // [R5]
   wire [4:0] next_oscEnable = srcEnable | {1'b0, lfTimer, extTimer, 2'b00};

   // Fuse decode used while reset holds.
   wire [3:0] fuseDecode = codeToIdx(lowFuse.sourceSelectFuses);
   wire [2:0] fuseIdx = fuseDecode[3] ? fuseDecode[2:0] : IDX_RC;
   wire [3:0] fuseCode = fuseDecode[3] ? lowFuse.sourceSelectFuses : CODE_RC;

   // Reset delay in clk cycles for the selected source and start-up setting.
   logic [22:0] rsDelay;
   always_comb begin
      rsDelay = 23'h0;
      if (sysIdx == IDX_LF) begin
         rsDelay = (selReg.startupTimeField == 2'h0) ? 23'(DELAY_SHORT_CYC) : 23'(DELAY_LONG_CYC); // [R1]
      end else if (selReg.startupTimeField == 2'h0) begin
         rsDelay = lowFuse.resetPinDisableFuse ? 23'(DELAY_PIN_CYC) : 23'h0; // [R4]
      end else if (selReg.startupTimeField == 2'h1) begin
         rsDelay = 23'(DELAY_SHORT_CYC); // [R3]
      end else begin
         rsDelay = 23'(DELAY_LONG_CYC); // [R3]
      end
   end

   // Read data selection.
   logic [31:0] readData;
   always_comb begin
      readData = 32'h0;
      case (apbReq.paddr)
         ADDR_SELECT: readData = {25'h0, selReg};
         ADDR_COMMAND: begin
            readData[CSR_CCE_BIT] = unlocked;
            readData[CSR_BUSY_BIT] = counting;
            readData[CSR_RDY_BIT] = srcReady;
         end
         ADDR_STATUS: readData = {21'h0, resetDone, ~swIdle, srcEnable, sysCode};
         default: readData = 32'h0;
      endcase
   end

   // Clock output is allowed only after reset and with no crystal running.
   wire crystalInUse = oscEnable[IDX_XTAL] | oscEnable[IDX_LF];
   wire clockOutAllowed = resetDone & selReg.clockOutputBit & ~crystalInUse; // [R6] [R7]

   // APB answer: ready one cycle into the access phase, data held with it.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         apbRsp <= '0;
      end else begin
         apbRsp.pready <= apbReq.psel & apbReq.penable & ~apbRsp.pready;
         apbRsp.prdata <= readData;
         apbRsp.pslverr <= apbReq.psel & apbReq.penable & ~apbRsp.pready & ~mapped;
      end
   end

   // Unlock window: armed by the unlock write, dropped by the next access or by age.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         unlocked <= 1'b0;
         unlockAge <= 3'h0;
      end else if (unlockHit) begin
         unlocked <= 1'b1; // [R23]
         unlockAge <= 3'h0;
      end else if (apbDone | (unlocked & (unlockAge == UNLOCK_LIFE - 3'h1))) begin
         unlocked <= 1'b0; // [R27]
      end else if (unlocked) begin
         unlockAge <= unlockAge + 3'h1;
      end
   end

   // Selection register: fuse copy at reset, then software or recover.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         selReg <= {~lowFuse.clockOutputFuse, lowFuse.startupFuses, lowFuse.sourceSelectFuses}; // [R12]
      end else if (selWrite) begin
         selReg <= apbReq.pwdata[6:0];
      end else if (doRecover) begin
         selReg.sourceSelectField <= sysCode; // [R20]
      end
   end

   // Source enables and the oscillator enable outputs.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         srcEnable <= 5'(5'h01 << fuseIdx);
         oscEnable <= 5'(5'h01 << fuseIdx);
      end else begin
         srcEnable <= next_srcEnable; // [R14] [R17]
         oscEnable <= next_oscEnable; // [R2] [R5]
      end
   end

   // Availability counter: clears ready at start, sets it at the limit.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         srcReady <= 1'b0;
         counting <= 1'b0;
         countIdx <= IDX_RC;
         countLimit <= LIM_FAST;
         countValue <= 16'h0;
      end else if (countStart) begin
         srcReady <= 1'b0; // [R19]
         counting <= 1'b1; // [R15]
         countIdx <= selIdx;
         countLimit <= startLimit(selReg.sourceSelectField, selReg.startupTimeField); // [R1] [R3]
         countValue <= 16'h0;
      end else if (counting & sourceTick[countIdx]) begin
         if (countValue == countLimit - 16'h1) begin
            counting <= 1'b0;
            srcReady <= 1'b1; // [R18]
         end else begin
            countValue <= countValue + 16'h1;
         end
      end
   end

   // Switch sequencer: old gate closes on an old edge, new opens on a new edge.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         swState <= SW_IDLE;
         swIdx <= IDX_RC;
         swCode <= CODE_RC;
         sysIdx <= fuseIdx;
         sysCode <= fuseCode;
         sysGate <= 5'(5'h01 << fuseIdx);
      end else begin
         case (swState)
            SW_IDLE: begin
               if (doSwitch) begin
                  swIdx <= selIdx; // [R21]
                  swCode <= selReg.sourceSelectField;
                  swState <= SW_DROP_OLD;
               end
            end
            SW_DROP_OLD: begin
               if (sourceTick[sysIdx]) begin
                  sysGate <= 5'h00; // [R9]
                  swState <= SW_TAKE_NEW;
               end
            end
            SW_TAKE_NEW: begin
               if (sourceTick[swIdx]) begin
                  sysGate <= 5'(5'h01 << swIdx); // [R9]
                  sysIdx <= swIdx;
                  sysCode <= swCode;
                  swState <= SW_IDLE;
               end
            end
            default: swState <= SW_IDLE;
         endcase
      end
   end

   // Reset delay: source cycles first (not for the low-frequency crystal), then clk cycles.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rsState <= RS_TICKS;
         rsCount <= 23'h0;
         resetDone <= 1'b0;
      end else begin
         resetDone <= (rsState == RS_DONE);
         case (rsState)
            RS_TICKS: begin
               if (sysIdx == IDX_LF) begin
                  rsState <= RS_WAIT; // [R1]
               end else if (sourceTick[sysIdx]) begin
                  if (rsCount == RST_SOURCE_TICKS - 23'h1) begin
                     rsCount <= 23'h0;
                     rsState <= RS_WAIT; // [R3]
                  end else begin
                     rsCount <= rsCount + 23'h1;
                  end
               end
            end
            RS_WAIT: begin
               if (rsCount >= rsDelay) begin
                  rsState <= RS_DONE; // [R4]
               end else begin
                  rsCount <= rsCount + 23'h1;
               end
            end
            RS_DONE: rsState <= RS_DONE;
            default: rsState <= RS_TICKS;
         endcase
      end
   end

   // Clock output pin follows the prescaled system clock ticks.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clockOutPin <= 1'b0;
         clockOutOe <= 1'b0;
         wdAutoReload <= 1'b0;
      end else begin
         clockOutOe <= clockOutAllowed; // [R6] [R7]
         clockOutPin <= clockOutAllowed & (divTick ? ~clockOutPin : clockOutPin); // [R8]
         wdAutoReload <= wdAutoReload | doWdAuto; // [R24]
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // The unlock lapses after its fourth cycle when no access intervenes.
   property p_unlock_expire;
      unlocked && (unlockAge == UNLOCK_LIFE - 3'h1) && !apbDone |=> !unlocked;
   endproperty
   a_unlock_expire: assert property (p_unlock_expire) else $error("unlock did not expire"); // [R27]

   // A command write without unlock changes no enable.
   property p_locked;
      cmdWrite && !unlocked && !unlockHit |=> $stable(srcEnable);
   endproperty
   a_locked: assert property (p_locked) else $error("locked command had effect"); // [R10]

   // Count start clears ready and runs the counter.
   property p_ready_clear;
      countStart |=> !srcReady && counting;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared at start"); // [R19]

   // With no count starting or running, ready keeps its value.
   property p_ready_hold;
      !countStart && !counting |=> $stable(srcReady);
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready changed without count"); // [R19]

   // The last counted tick sets ready.
   property p_count_done;
      counting && !countStart && sourceTick[countIdx] && (countValue == countLimit - 16'h1) |=> srcReady;
   endproperty
   a_count_done: assert property (p_count_done) else $error("ready not set at limit"); // [R18]

   // Disabling the system source is refused.
   property p_disable_sys;
      execCmd && (cmdByte == CMD_DISABLE) && (selIdx == sysIdx) |=> srcEnable[$past(sysIdx)];
   endproperty
   a_disable_sys: assert property (p_disable_sys) else $error("system source was disabled"); // [R16]

   // Never two system gates open at once.
   property p_gate_onehot;
      $onehot0(sysGate);
   endproperty
   a_gate_onehot: assert property (p_gate_onehot) else $error("two system gates open"); // [R9]

   // At most one external source enabled.
   property p_ext_one;
      $onehot0(srcEnable[4:2]) && $onehot0(oscEnable[4:2]);
   endproperty
   a_ext_one: assert property (p_ext_one) else $error("two external sources enabled"); // [R25]

   // No clock output while the reset delay runs.
   property p_clkout_reset;
      !resetDone |=> !clockOutOe && !clockOutPin;
   endproperty
   a_clkout_reset: assert property (p_clkout_reset) else $error("clock output during reset"); // [R7]

   // Recover loads the system code into the select field.
   property p_recover;
      doRecover |=> selReg.sourceSelectField == $past(sysCode);
   endproperty
   a_recover: assert property (p_recover) else $error("recover gave wrong code"); // [R20]

   // The low-frequency crystal with setting 10 counts the long limit.
   property p_lf_limit;
      countStart && (selReg.sourceSelectField == CODE_LF) && (selReg.startupTimeField == 2'h2)
         |=> countLimit == LIM_32K;
   endproperty
   a_lf_limit: assert property (p_lf_limit) else $error("wrong low-frequency limit"); // [R1]
endmodule

// file: src/clock_switch_pkg.sv
// Purpose: Shared constants, types and register layout of the dynamic clock switch.
// Assumes: One 125 MHz system clock; register bus is APB with 32-bit data.
// Notes: Source codes and register offsets are fixed here and used by the block.
package clock_switch_pkg;
   // Clock rate used to turn delays into cycle counts.
   localparam real CLK_PERIOD_NS = 8.0;
   // Reset delays, in milliseconds, and their cycle counts (least times round up).
   localparam real RST_DELAY_SHORT_MS = 4.1;
   localparam real RST_DELAY_PIN_MS = 4.0;
   localparam real RST_DELAY_LONG_MS = 65.0;
   localparam int RST_DELAY_SHORT_CYC = int'($ceil(RST_DELAY_SHORT_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int RST_DELAY_PIN_CYC = int'($ceil(RST_DELAY_PIN_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int RST_DELAY_LONG_CYC = int'($ceil(RST_DELAY_LONG_MS * 1.0e6 / CLK_PERIOD_NS));
   // Source cycles counted after reset before the reset delay proper.
   localparam logic [22:0] RST_SOURCE_TICKS = 23'h00000E;
   // Register byte offsets.
   localparam logic [7:0] ADDR_SELECT = 8'h00;
   localparam logic [7:0] ADDR_COMMAND = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // Command register bit positions on read.
   localparam int CSR_CCE_BIT = 7;
   localparam int CSR_BUSY_BIT = 5;
   localparam int CSR_RDY_BIT = 4;
   // Command byte encodings.
   localparam logic [7:0] CMD_UNLOCK = 8'h80;
   localparam logic [7:0] CMD_DISABLE = 8'h01;
   localparam logic [7:0] CMD_ENABLE = 8'h02;
   localparam logic [7:0] CMD_REQUEST = 8'h03;
   localparam logic [7:0] CMD_SWITCH = 8'h04;
   localparam logic [7:0] CMD_RECOVER = 8'h05;
   localparam logic [7:0] CMD_WD_AUTO = 8'h06;
   // Cycles an unlock stays armed.
   localparam logic [2:0] UNLOCK_LIFE = 3'h4;
   // Source indices; external sources are EXT and above.
   localparam logic [2:0] IDX_RC = 3'h0;
   localparam logic [2:0] IDX_WD = 3'h1;
   localparam logic [2:0] IDX_EXT = 3'h2;
   localparam logic [2:0] IDX_LF = 3'h3;
   localparam logic [2:0] IDX_XTAL = 3'h4;
   localparam logic [4:0] EXT_MASK = 5'h1C;
   // Source codes of the select field; any code with bit 3 set is the crystal.
   localparam logic [3:0] CODE_EXT = 4'h0;
   localparam logic [3:0] CODE_RC = 4'h2;
   localparam logic [3:0] CODE_WD = 4'h3;
   localparam logic [3:0] CODE_LF = 4'h6;
   localparam logic [1:0] SUT_RESERVED = 2'h3;
   // Availability count limits in source cycles.
   localparam logic [15:0] LIM_FAST = 16'h0006;
   localparam logic [15:0] LIM_258 = 16'h0102;
   localparam logic [15:0] LIM_1K = 16'h0400;
   localparam logic [15:0] LIM_16K = 16'h4000;
   localparam logic [15:0] LIM_32K = 16'h8000;
   // Clock selection register layout, read and written in bits 6:0.
   typedef struct packed {
      logic clockOutputBit;
      logic [1:0] startupTimeField;
      logic [3:0] sourceSelectField;
   } sel_reg_t;
   // Low fuse byte as seen by the block.
   typedef struct packed {
      logic resetPinDisableFuse;
      logic clockOutputFuse;
      logic [1:0] startupFuses;
      logic [3:0] sourceSelectFuses;
   } fuse_t;
   // APB request from the master.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   // APB answer of this slave.
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
   typedef enum logic [1:0] {SW_IDLE, SW_DROP_OLD, SW_TAKE_NEW} switch_state_t;
   typedef enum logic [1:0] {RS_TICKS, RS_WAIT, RS_DONE} reset_state_t;
endpackage

// file: tb/testbench.sv
// Purpose: Self-checking bench for the dynamic clock switch, driven over APB.
// Assumes: Source and prescaler ticks arrive every other cycle; reset delays are shortened.
// Notes: Requests stay up between back-to-back calls; idle releases the bus.
`timescale 1ns/100ps
module testbench;
   import clock_switch_pkg::*;
   logic clk = 1'b0; // System clock.
   logic rstn = 1'b0; // Active-low reset.
   apb_req_t apbReq = '0; // Bus request.
   apb_rsp_t apbRsp; // Bus answer.
   fuse_t lowFuse = 8'h02; // RC source, start-up 00, output fuse programmed.
   logic [4:0] sourceTick = '0; // Oscillation ticks.
   logic divTick = 1'b0; // Prescaled ticks.
   logic timerWantsLf = 1'b0; // Timer asks for the low-frequency source.
   logic timerWantsExt = 1'b0; // Timer asks for the external input.
   logic tk = 1'b0; // Phase that spaces the ticks.
   logic [4:0] oscEnable;
   logic [4:0] sysGate;
   logic clockOutPin;
   logic clockOutOe;
   logic wdAutoReload;
   logic resetDone;
   logic [31:0] q; // Last read data.
   logic perr; // Last error response.
   logic pinWas; // Previous output pin level.
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   clock_switch #(.DELAY_SHORT_CYC(20), .DELAY_PIN_CYC(16), .DELAY_LONG_CYC(40)) clock_switch_inst (
      .clk(clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp), .lowFuse(lowFuse),
      .sourceTick(sourceTick), .divTick(divTick), .timerWantsLf(timerWantsLf),
      .timerWantsExt(timerWantsExt), .oscEnable(oscEnable), .sysGate(sysGate),
      .clockOutPin(clockOutPin), .clockOutOe(clockOutOe), .wdAutoReload(wdAutoReload),
      .resetDone(resetDone));
   always #4 clk = ~clk;
   // Ticks every other cycle, and a ceiling on run length.
   always @(posedge clk) begin
      tk <= ~tk;
      sourceTick <= {5{tk}};
      divTick <= tk;
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         close_out();
      end
   end
   // Prints the verdict and ends the run.
   task automatic close_out();
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      @(posedge clk);
      while (apbRsp.pready !== 1'b1) @(posedge clk);
      q = apbRsp.prdata;
      perr = apbRsp.pslverr;
   endtask
   // Releases the bus and waits k cycles.
   task automatic idle(input int k);
      apbReq <= '0;
      repeat (k) @(posedge clk);
   endtask
   // Unlock write followed at once by the command write.
   task automatic cmd(input logic [7:0] c);
      xfer(1'b1, ADDR_COMMAND, {24'h0, CMD_UNLOCK});
      xfer(1'b1, ADDR_COMMAND, {24'h0, c});
      idle(2);
   endtask
   // Reads a register and compares the masked value.
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(what, q & m, e);
      idle(1);
   endtask
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk);
      chk("oe in reset", {31'h0, clockOutOe}, 32'h0);
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (60) @(posedge clk);
      rdc("select", ADDR_SELECT, 32'hFF, 32'h42);
      rdc("status", ADDR_STATUS, 32'h7FF, {21'h0, 1'b1, 1'b0, 5'h01, CODE_RC});
      chk("oe", {31'h0, clockOutOe}, 32'h1);
      n = 0;
      pinWas = clockOutPin;
      repeat (16) begin
         @(posedge clk);
         if (clockOutPin !== pinWas) n++;
         pinWas = clockOutPin;
      end
      chk("pin toggles", n, 32'h8);
      timerWantsLf <= 1'b1;
      idle(4);
      chk("timer lf", {31'h0, oscEnable[IDX_LF]}, 32'h1);
      chk("oe lf", {31'h0, clockOutOe}, 32'h0);
      timerWantsLf <= 1'b0;
      idle(4);
      timerWantsExt <= 1'b1;
      idle(4);
      chk("timer ext", {31'h0, oscEnable[IDX_EXT]}, 32'h1);
      timerWantsExt <= 1'b0;
      idle(4);
      xfer(1'b0, 8'h0C, 32'h0);
      chk("slverr", {31'h0, perr}, 32'h1);
      chk("unmapped data", q, 32'h0);
      xfer(1'b1, ADDR_SELECT, 32'h40);
      xfer(1'b1, ADDR_COMMAND, {24'h0, CMD_ENABLE});
      idle(3);
      rdc("no unlock", ADDR_STATUS, 32'h1F0, 32'h010);
      xfer(1'b1, ADDR_COMMAND, {24'h0, CMD_UNLOCK});
      idle(6);
      xfer(1'b1, ADDR_COMMAND, {24'h0, CMD_ENABLE});
      idle(3);
      rdc("expired", ADDR_STATUS, 32'h1F0, 32'h010);
      cmd(8'h07);
      rdc("undefined", ADDR_STATUS, 32'h1F0, 32'h010);
      cmd(CMD_ENABLE);
      rdc("ready cleared", ADDR_COMMAND, 32'h10, 32'h00);
      idle(20);
      rdc("ready set", ADDR_COMMAND, 32'h10, 32'h10);
      rdc("enables", ADDR_STATUS, 32'h1F0, 32'h050);
      cmd(CMD_SWITCH);
      idle(10);
      xfer(1'b1, ADDR_SELECT, 32'h72);
      cmd(CMD_RECOVER);
      rdc("recover", ADDR_SELECT, 32'hFF, {24'h0, 4'h7, CODE_EXT});
      rdc("system", ADDR_STATUS, 32'h00F, {28'h0, CODE_EXT});
      chk("gate", {27'h0, sysGate}, 32'h04);
      xfer(1'b1, ADDR_SELECT, 32'h42);
      cmd(CMD_DISABLE);
      rdc("disable rc", ADDR_STATUS, 32'h1F0, 32'h040);
      xfer(1'b1, ADDR_SELECT, 32'h40);
      cmd(CMD_DISABLE);
      rdc("disable sys", ADDR_STATUS, 32'h1F0, 32'h040);
      // The low-frequency source with setting 10 starts a long count that is still busy when read.
      xfer(1'b1, ADDR_SELECT, 32'h26);
      cmd(CMD_REQUEST);
      rdc("request", ADDR_COMMAND, 32'h30, 32'h20);
      cmd(CMD_WD_AUTO);
      chk("auto reload", {31'h0, wdAutoReload}, 32'h1);
      // A second reset with external clock fuses, the reset-pin fuse set and clock output off.
      lowFuse <= 8'hC0;
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (38) @(posedge clk);
      chk("pin fuse delay", {31'h0, resetDone}, 32'h0);
      repeat (22) @(posedge clk);
      chk("auto reload reset", {31'h0, wdAutoReload}, 32'h0);
      rdc("select fuse", ADDR_SELECT, 32'hFF, 32'h00);
      rdc("status fuse", ADDR_STATUS, 32'h7FF, 32'h440);
      chk("oe off", {31'h0, clockOutOe}, 32'h0);
      close_out();
   end
endmodule
